// >>> core/ce_update_framer.sv
// Sender end: serialises octets 2 onward to the lowest-carrier field
// Assumes caller holds fields stable from start until done
`timescale 1ns/1ns
`default_nettype none
`include "ce_update_defs.svh"
module ce_update_framer
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire ce_update_pkg::update_fields_t fields_i,
  output logic busy_o,
  output logic done_o,
  output logic error_o,
  ce_update_if.sender link
);
  import ce_update_pkg::*;

  framer_state_t state;
  framer_state_t next_state;
  logic [4:0] octet;
  logic [4:0] next_octet;
  logic [4:0] last_octet;
  logic [1:0] bmp_sel;
  logic [7:0] byte_out;
  logic valid;
  logic next_valid;
  logic first;
  logic next_first;
  logic last;
  logic next_last;
  logic [7:0] data;
  logic [7:0] next_data;
  logic done;
  logic next_done;
  logic err;
  logic next_err;
  logic busy;
  logic next_busy;
  logic [2:0] idx;

  // -------------------------------------------------
  // Field unpacking
  // -------------------------------------------------
  // Bitmap split into octets, table 8 in the lowest
  logic [7:0] bitmap_octet [`BITMAP_OCTETS];
  // Window codes split per window, first window at index 0
  logic [7:0] start_code [`MAX_WINDOWS];
  logic [7:0] end_code [`MAX_WINDOWS];
  genvar w;

  // One bitmap octet per entry
  generate
    for (w = 0; w < `BITMAP_OCTETS; w++)
    begin : g_bitmap
      assign bitmap_octet[w] = fields_i.valid_table_bitmap[8*w +: 8];
    end
  endgenerate

  // One start and end code per window; unused windows never sent
  generate
    for (w = 0; w < `MAX_WINDOWS; w++)
    begin : g_window
      assign start_code[w] = fields_i.window_start_codes[8*w +: 8];
      assign end_code[w] = fields_i.window_end_codes[8*w +: 8];
    end
  endgenerate

  // -------------------------------------------------
  // Octet layout
  // -------------------------------------------------
  // Final octet: 2V+9 is the carrier high octet
  // At most 25, so five bits hold every offset
  assign last_octet = 5'(2 * ({2'b00, fields_i.duration_count_minus_one} + 5'h1) + 9);
  assign idx = 3'((octet - `FIRST_WINDOW_OCTET) >> 1);
  // Bitmap octet number, 0 for the octet holding table 8
  assign bmp_sel = 2'(octet - `BITMAP_FIRST_OCTET);

  // Selects the octet at the current offset
  always_comb
  begin
    byte_out = 8'h00;
    if (octet >= `BITMAP_FIRST_OCTET && octet < `CAPACITY_OCTET)
      byte_out = bitmap_octet[bmp_sel];
    else if (octet == `CAPACITY_OCTET)
      byte_out = {2'b00, fields_i.spectral_peak_extension_flag,
                  fields_i.tx_table_capacity};
    else if (octet == `CODES_OCTET)
      byte_out = {fields_i.guard_interval_code, fields_i.correction_rate_code,
                  fields_i.block_size_code};
    else if (octet == `PEAK_OCTET)
      byte_out = {fields_i.duration_count_minus_one, fields_i.spectral_peak_value};
    else if (octet < last_octet - 5'h1)
    begin
      if (!octet[0])
        byte_out = start_code[idx];
      else
        byte_out = end_code[idx];
    end
    else if (octet == last_octet - 5'h1)
      byte_out = fields_i.lowest_loaded_carrier[7:0];
    else
      byte_out = {4'h0, fields_i.lowest_loaded_carrier[11:8]};
  end

  // -------------------------------------------------
  // Sequencer
  // -------------------------------------------------
  // Next state and stream outputs
  always_comb
  begin
    next_state = state;
    next_octet = octet;
    next_valid = 1'b0;
    next_first = 1'b0;
    next_last = 1'b0;
    next_data = data;
    next_done = 1'b0;
    next_err = err;
    case (state)
      ST_IDLE:
      begin
        if (start_i)
        begin
          next_state = ST_SEND;
          next_octet = `BITMAP_FIRST_OCTET;
          // Flags out-of-range capacity, sends anyway
          next_err = fields_i.tx_table_capacity > `CAPACITY_MAX;
        end
      end
      ST_SEND:
      begin
        next_valid = 1'b1;
        next_data = byte_out;
        next_first = octet == `BITMAP_FIRST_OCTET;
        next_last = octet == last_octet;
        next_octet = octet + 5'h1;
        if (octet == last_octet)
        begin
          next_state = ST_IDLE;
          next_done = 1'b1;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
    // Busy covers every cycle that still has an octet to send
    next_busy = next_state == ST_SEND;
  end

  // Registers state and outputs
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_IDLE;
      octet <= 5'h00;
      valid <= 1'b0;
      first <= 1'b0;
      last <= 1'b0;
      data <= 8'h00;
      done <= 1'b0;
      err <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      octet <= next_octet;
      valid <= next_valid;
      first <= next_first;
      last <= next_last;
      data <= next_data;
      done <= next_done;
      err <= next_err;
      busy <= next_busy;
    end
  end

  // -------------------------------------------------
  // Outputs
  // -------------------------------------------------
  assign link.valid = valid;
  assign link.first = first;
  assign link.last = last;
  assign link.data = data;
  assign busy_o = busy;
  assign done_o = done;
  assign error_o = err;
endmodule
`default_nettype wire

// >>> core/ce_update_defs.svh
// Octet offsets, field positions and limits of the estimate-update fields
// Assumes inclusion by bare name from the package and design files
`ifndef CE_UPDATE_DEFS_SVH
`define CE_UPDATE_DEFS_SVH
`define BITMAP_FIRST_OCTET 5'h02
`define CAPACITY_OCTET 5'h05
`define CODES_OCTET 5'h06
`define PEAK_OCTET 5'h07
`define FIRST_WINDOW_OCTET 5'h08
`define FIRST_TABLE_NUMBER 8
`define LAST_TABLE_NUMBER 31
`define CAPACITY_MAX 5'h18
`define EXT_FLAG_BIT 5
`define MAX_WINDOWS 8
`define BITMAP_OCTETS 3
`define CARRIER_WIDTH 12
`endif

// >>> core/ce_update_pkg.sv
// Field type shared by both ends of the estimate-update field link, and the framer state type
// Assumes the defs header is on the include path
`include "ce_update_defs.svh"
package ce_update_pkg;
  typedef struct packed {
    logic [23:0] valid_table_bitmap;
    logic [4:0] tx_table_capacity;
    logic spectral_peak_extension_flag;
    logic [1:0] block_size_code;
    logic [2:0] correction_rate_code;
    logic [2:0] guard_interval_code;
    logic [4:0] spectral_peak_value;
    logic [2:0] duration_count_minus_one;
    logic [63:0] window_start_codes;
    logic [63:0] window_end_codes;
    logic [11:0] lowest_loaded_carrier;
  } update_fields_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } framer_state_t;
endpackage

// >>> core/ce_update_if.sv
// Octet stream carrier between field framer and field parser
// Assumes both ends share one clock and reset
`timescale 1ns/1ns
`default_nettype none
interface ce_update_if;
  logic valid;
  logic first;
  logic last;
  logic [7:0] data;
  modport sender (output valid, output first, output last, output data);
  modport receiver (input valid, input first, input last, input data);
endinterface
`default_nettype wire

// >>> core/ce_update_parser.sv
// Receiver end: rebuilds fields from the octet stream and checks them
// Assumes stream from the framer on the same clock; group size is a level
`timescale 1ns/1ns
`default_nettype none
`include "ce_update_defs.svh"
module ce_update_parser
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [3:0] group_size_i,
  ce_update_if.receiver link,
  output ce_update_pkg::update_fields_t fields_o,
  output logic fields_valid_o,
  output logic carrier_invalid_o,
  output logic overlap_o
);
  import ce_update_pkg::*;

  update_fields_t f, next_f;
  logic [4:0] octet, next_octet;
  logic [4:0] last_octet;
  logic [2:0] idx;
  logic fv, next_fv, ci, next_ci, ov, next_ov;
  logic [11:0] carrier;
  logic [11:0] rem;
  logic overlap;

  assign last_octet = 5'(2 * ({2'b00, f.duration_count_minus_one} + 5'h1) + 9);
  assign idx = 3'((octet - `FIRST_WINDOW_OCTET) >> 1);
  assign carrier = {link.data[3:0], f.lowest_loaded_carrier[7:0]};
  assign rem = (group_size_i == 4'h0) ? 12'h000 : carrier % {8'h00, group_size_i};

  // Pairwise overlap check over declared windows
  always_comb
  begin
    overlap = 1'b0;
    for (int a = 0; a < `MAX_WINDOWS; a++)
      for (int b = 0; b < `MAX_WINDOWS; b++)
        if (a < b && b <= int'(f.duration_count_minus_one) &&
            f.window_start_codes[8*a +: 8] <= f.window_end_codes[8*b +: 8] &&
            f.window_start_codes[8*b +: 8] <= f.window_end_codes[8*a +: 8])
          overlap = 1'b1;
  end

  // Field capture per octet offset
  always_comb
  begin
    next_f = f;
    next_octet = octet;
    next_fv = 1'b0;
    next_ci = ci;
    next_ov = ov;
    if (link.valid)
    begin
      if (link.first)
        next_octet = `BITMAP_FIRST_OCTET + 5'h1;
      else
        next_octet = octet + 5'h1;
      if (link.first)
        next_f.valid_table_bitmap[7:0] = link.data;
      else if (octet < `CAPACITY_OCTET)
        next_f.valid_table_bitmap[8*(octet-`BITMAP_FIRST_OCTET) +: 8] = link.data;
      else if (octet == `CAPACITY_OCTET)
      begin
        next_f.tx_table_capacity = link.data[4:0];
        next_f.spectral_peak_extension_flag = link.data[`EXT_FLAG_BIT];
      end
      else if (octet == `CODES_OCTET)
      begin
        next_f.block_size_code = link.data[1:0];
        next_f.correction_rate_code = link.data[4:2];
        next_f.guard_interval_code = link.data[7:5];
      end
      else if (octet == `PEAK_OCTET)
      begin
        next_f.spectral_peak_value = link.data[4:0];
        next_f.duration_count_minus_one = link.data[7:5];
      end
      else if (octet < last_octet - 5'h1)
      begin
        if (!octet[0])
          next_f.window_start_codes[8*idx +: 8] = link.data;
        else
          next_f.window_end_codes[8*idx +: 8] = link.data;
      end
      else if (octet == last_octet - 5'h1)
        next_f.lowest_loaded_carrier[7:0] = link.data;
      else
      begin
        next_f.lowest_loaded_carrier[11:8] = link.data[3:0];
        next_fv = 1'b1;
        next_ci = rem != 12'h000;
        next_ov = overlap;
      end
    end
  end

  // Registers captured fields and flags
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      f <= '0;
      octet <= 5'h00;
      fv <= 1'b0;
      ci <= 1'b0;
      ov <= 1'b0;
    end
    else
    begin
      f <= next_f;
      octet <= next_octet;
      fv <= next_fv;
      ci <= next_ci;
      ov <= next_ov;
    end
  end

  assign fields_o = f;
  assign fields_valid_o = fv;
  assign carrier_invalid_o = ci;
  assign overlap_o = ov;
endmodule
`default_nettype wire

// >>> tb/ce_update_chk.sv
// Checker on the octet stream between framer and parser
// Assumes one clock and the link signals as plain inputs
`timescale 1ns/1ns
`default_nettype none
module ce_update_chk
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic valid,
  input wire logic first,
  input wire logic last,
  input wire logic [7:0] data
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [2:0] code;
  logic [2:0] next_code;
  // Octet index and captured duration code
  always_comb
  begin
    next_cnt = cnt;
    next_code = code;
    if (valid)
      next_cnt = first ? 5'h01 : cnt + 5'h01;
    if (valid && !first && cnt == 5'h05)
      next_code = data[7:5];
  end
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt <= 5'h00;
      code <= 3'h0;
    end
    else
    begin
      cnt <= next_cnt;
      code <= next_code;
    end
  end
  sequence s_head;
    valid && first;
  endsequence
  chk_first_valid: assert property (first |-> valid)
    else $error("first without valid");
  chk_last_valid: assert property (last |-> valid)
    else $error("last without valid");
  chk_head_run: assert property (s_head |=> valid [*8])
    else $error("gap in frame");
  chk_no_early: assert property (s_head |-> !last ##1 !last [*8])
    else $error("frame too short");
  chk_reserved_zero: assert property (s_head |-> ##3 data[7:6] == 2'b00)
    else $error("reserved bits set");
  chk_frame_length: assert property (last && !first |-> cnt == {1'b0, code, 1'b1} + 5'h08)
    else $error("wrong frame length");
  chk_carrier_high: assert property (last |-> data[7:4] == 4'h0)
    else $error("carrier high nibble set");
  chk_stream_start: assert property ($rose(valid) |-> first)
    else $error("frame not started by first");
endmodule
`default_nettype wire

// >>> tb/channel_estimate_update_fields_tb_top.sv
// Testbench joining framer and parser through the link
// Assumes the package and interface are compiled first
`timescale 1ns/1ns
`default_nettype none
module channel_estimate_update_fields_tb_top;
  import ce_update_pkg::*;
  logic clock_i = 0;
  logic resetn_i = 0;
  logic start_i = 0;
  logic [3:0] group_size_i = 4'h0;
  update_fields_t fields_i = '0;
  update_fields_t fields_o;
  update_fields_t got;
  update_fields_t exp_f;
  update_fields_t exp_q[$];
  logic [2:0] flag_q[$];
  logic busy_o, done_o, error_o, fields_valid_o, carrier_invalid_o, overlap_o;
  int bad_count = 0;
  int total_checks = 0;
  bit timed_out = 1'b0;
  int seed = 32'h039d9e95;
  ce_update_if ce_update_if_i();
  ce_update_framer ce_update_framer_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .start_i(start_i), .fields_i(fields_i), .busy_o(busy_o), .done_o(done_o),
    .error_o(error_o), .link(ce_update_if_i));
  ce_update_parser ce_update_parser_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .group_size_i(group_size_i), .link(ce_update_if_i), .fields_o(fields_o),
    .fields_valid_o(fields_valid_o), .carrier_invalid_o(carrier_invalid_o),
    .overlap_o(overlap_o));
  ce_update_chk ce_update_chk_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .valid(ce_update_if_i.valid), .first(ce_update_if_i.first),
    .last(ce_update_if_i.last), .data(ce_update_if_i.data));
  // Clock generation
  initial
  begin
    forever #4 clock_i = ~clock_i;
  end
  task automatic check(input logic [191:0] seen, input logic [191:0] want);
    total_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One frame: random fields, special cases by frame number
  task automatic send(input int n);
    logic [191:0] r;
    logic [3:0] g;
    int k;
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
      $random(seed)};
    fields_i = r[185:0];
    fields_i.duration_count_minus_one = 3'(n);
    fields_i.tx_table_capacity = (n == 8) ? 5'h19 : 5'($unsigned($random(seed)) % 25);
    for (int i = 0; i < 8; i++)
    begin
      fields_i.window_start_codes[8*i+:8] = 8'(32 * i);
      fields_i.window_end_codes[8*i+:8] = 8'(32 * i + 9 + i);
    end
    if (n == 9)
      fields_i.window_start_codes[15:8] = 8'h05;
    g = (n == 11) ? 4'h0 : (n == 10) ? 4'h3 : 4'(1 + $unsigned($random(seed)) % 15);
    fields_i.lowest_loaded_carrier = 12'(g * ($unsigned($random(seed)) % 200) + (n >= 10));
    group_size_i = g;
    exp_q.push_back(fields_i);
    flag_q.push_back({n == 8, n == 10, n == 9});
    start_i = 1;
    @(negedge clock_i);
    start_i = 0;
    check(192'(busy_o), 192'h1);
    k = 0;
    while (done_o !== 1'b1 && k < 40)
    begin
      @(negedge clock_i);
      k++;
    end
    if (k == 40)
    begin
      bad_count++;
      timed_out = 1'b1;
    end
    @(negedge clock_i);
  endtask
  // Compares parsed fields and flags against the oldest note
  always @(negedge clock_i)
  begin
    if (ce_update_if_i.last === 1'b1)
      check(192'({done_o, busy_o}), 192'h2);
    if (fields_valid_o === 1'b1)
    begin
      got = fields_o;
      exp_f = exp_q.pop_front();
      for (int i = 8; i > exp_f.duration_count_minus_one + 1; i--)
      begin
        got.window_start_codes[8*i-8+:8] = 8'h00;
        got.window_end_codes[8*i-8+:8] = 8'h00;
        exp_f.window_start_codes[8*i-8+:8] = 8'h00;
        exp_f.window_end_codes[8*i-8+:8] = 8'h00;
      end
      check(192'(got), 192'(exp_f));
      check(192'({error_o, carrier_invalid_o, overlap_o}), 192'(flag_q.pop_front()));
    end
  end
  // Main sequence
  initial
  begin
    repeat (6) @(negedge clock_i);
    resetn_i = 1;
    for (int n = 0; n < 12 && !timed_out; n++)
      send(n);
    repeat (4) @(negedge clock_i);
    check(192'(exp_q.size()), 192'h0);
    summarize();
  end
endmodule
`default_nettype wire
